// [logic/phy_mode_config_decoder.sv]
// Operation
// - scramble chips only if enable set, o-qpsk, and payload rate code 2
// - receiver decodes with scrambler, modulation, chip rate and payload rate
// - shaping select used only at high chip rate o-qpsk: half-sine or rc-0.8
// - receive path never looks at the shaping select field
// - modulation select 0 gives bpsk, 1 gives o-qpsk, for tx and rx
// - high chip rate: 1000 kchip/s o-qpsk, 600 kchip/s bpsk at 40 kbit/s
// - low chip rate: 400 kchip/s o-qpsk, 300 kchip/s bpsk at 20 kbit/s
// - low chip rate o-qpsk always sends half-sine plus rc-0.2 shaping
// - o-qpsk payload rate code sets psdu rate 1x, 2x, 4x; code 3 reserved; bpsk ignores it
// - top two register bits play no part in mode selection
module phy_mode_config_decoder
    import phy_mode_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        clk_en_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    input  wire logic        transceiver_off_state_i,
    output logic [7:0]       reg_rdata_o,
    output logic [7:0]       phy_mode_control_o,
    output modulation_t      tx_modulation_o,
    output modulation_t      rx_modulation_o,
    output shaping_t         tx_shaping_o,
    output logic [9:0]       chip_rate_kchip_o,
    output logic             rx_chip_rate_hi_o,
    output logic [9:0]       header_rate_kbit_o,
    output logic [9:0]       psdu_rate_kbit_o,
    output logic [1:0]       rx_payload_rate_sel_o,
    output logic             rate_reserved_o,
    output logic             tx_scrambler_on_o,
    output logic             rx_scrambler_on_o,
    output logic             cfg_write_active_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rdata;
        phy_mode_t  mode;
        logic       write_active;
    } state_t;

    localparam state_t STATE_RST = '{
        cfg:          PHY_MODE_CONTROL_RST,
        rdata:        READ_UNMAPPED_VAL,
        mode:         PHY_MODE_RST,
        write_active: 1'b0
    };

    state_t     state_r;
    state_t     state_nxt;
    logic       hit;
    logic [7:0] cfg_next;

    phy_mode_if mode_bus ();

    // ------------------------------------------------------------
    // decode of the register value that is about to be stored
    // ------------------------------------------------------------
    phy_mode_decode u_decode (
        .dec (mode_bus.decoder)
    );

    assign hit          = (reg_addr_i == PHY_MODE_CONTROL_ADDR);
    assign cfg_next     = (reg_wr_i && hit) ? reg_wdata_i : state_r.cfg;
    assign mode_bus.cfg = cfg_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        // all eight bits are read/write; the top two are stored only
        state_nxt.cfg  = cfg_next;
        // decoded settings land on the same edge as the write
        state_nxt.mode = mode_bus.mode;
        // mode change while the transceiver is not off is flagged;
        // software owns that ordering, the write still takes effect
        if (reg_wr_i && hit) begin
            state_nxt.write_active = !transceiver_off_state_i;
        end
        // registered read: unmapped addresses return zero
        if (reg_rd_i) begin
            state_nxt.rdata = hit ? state_r.cfg : READ_UNMAPPED_VAL;
        end
    end

    // ------------------------------------------------------------
    // state register, frozen while the clock enable is low
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= STATE_RST;
        end else if (clk_en_i) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // transmit side outputs
    // ------------------------------------------------------------
    assign reg_rdata_o        = state_r.rdata;
    assign phy_mode_control_o = state_r.cfg;
    assign tx_modulation_o    = state_r.mode.modulation;
    assign tx_shaping_o       = state_r.mode.tx_shaping;
    assign chip_rate_kchip_o  = state_r.mode.chip_kchip;
    assign header_rate_kbit_o = state_r.mode.header_kbit;
    assign psdu_rate_kbit_o   = state_r.mode.psdu_kbit;
    assign rate_reserved_o    = state_r.mode.rate_reserved;
    assign tx_scrambler_on_o  = state_r.mode.scrambler_on;
    assign cfg_write_active_o = state_r.write_active;

    // ------------------------------------------------------------
    // receive side outputs: same four settings, no shaping
    // ------------------------------------------------------------
    assign rx_modulation_o       = state_r.mode.modulation;
    assign rx_chip_rate_hi_o     = state_r.cfg[CHIP_RATE_BIT];
    assign rx_payload_rate_sel_o =
        state_r.cfg[RATE_SEL_MSB:RATE_SEL_LSB];
    assign rx_scrambler_on_o     = state_r.mode.scrambler_on;

endmodule

// [logic/phy_mode_pkg.sv]
package phy_mode_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] PHY_MODE_CONTROL_ADDR = 8'h0c;
    localparam logic [7:0] PHY_MODE_CONTROL_RST  = 8'h24;
    localparam logic [7:0] READ_UNMAPPED_VAL     = 8'h00;

    // ------------------------------------------------------------
    // field positions of phy_mode_control
    // ------------------------------------------------------------
    localparam int SCRAM_EN_BIT   = 5;
    localparam int RC_SHAPE_BIT   = 4;
    localparam int MOD_SEL_BIT    = 3;
    localparam int CHIP_RATE_BIT  = 2;
    localparam int RATE_SEL_MSB   = 1;
    localparam int RATE_SEL_LSB   = 0;
    localparam int MODE_FIELD_MSB = 5;

    // ------------------------------------------------------------
    // payload rate select codes
    // ------------------------------------------------------------
    localparam logic [1:0] RATE_SEL_BASE  = 2'h0;
    localparam logic [1:0] RATE_SEL_X2    = 2'h1;
    localparam logic [1:0] RATE_SEL_X4    = 2'h2;
    localparam logic [1:0] RATE_SEL_RSVD  = 2'h3;

    // ------------------------------------------------------------
    // chip rates in kchip/s, data rates in kbit/s
    // ------------------------------------------------------------
    localparam logic [9:0] KCHIP_BPSK_LO  = 10'h12c; // 300
    localparam logic [9:0] KCHIP_BPSK_HI  = 10'h258; // 600
    localparam logic [9:0] KCHIP_OQPSK_LO = 10'h190; // 400
    localparam logic [9:0] KCHIP_OQPSK_HI = 10'h3e8; // 1000
    localparam logic [9:0] KBIT_BPSK_LO   = 10'h014; // 20
    localparam logic [9:0] KBIT_BPSK_HI   = 10'h028; // 40
    localparam logic [9:0] KBIT_OQ_LO_X1  = 10'h064; // 100
    localparam logic [9:0] KBIT_OQ_LO_X2  = 10'h0c8; // 200
    localparam logic [9:0] KBIT_OQ_LO_X4  = 10'h190; // 400
    localparam logic [9:0] KBIT_OQ_HI_X1  = 10'h0fa; // 250
    localparam logic [9:0] KBIT_OQ_HI_X2  = 10'h1f4; // 500
    localparam logic [9:0] KBIT_OQ_HI_X4  = 10'h3e8; // 1000
    localparam logic [9:0] KBIT_NONE      = 10'h000;

    // ------------------------------------------------------------
    // decoded mode types
    // ------------------------------------------------------------
    typedef enum logic {
        MOD_BPSK,
        MOD_OQPSK
    } modulation_t;

    typedef enum logic [1:0] {
        SHAPE_RC_1_0,
        SHAPE_HALF_SINE,
        SHAPE_RC_0_8,
        SHAPE_SIN_RC_0_2
    } shaping_t;

    typedef struct packed {
        modulation_t modulation;
        shaping_t    tx_shaping;
        logic [9:0]  chip_kchip;
        logic [9:0]  header_kbit;
        logic [9:0]  psdu_kbit;
        logic        rate_reserved;
        logic        scrambler_on;
    } phy_mode_t;

    localparam phy_mode_t PHY_MODE_RST = '{
        modulation:    MOD_BPSK,
        tx_shaping:    SHAPE_RC_1_0,
        chip_kchip:    KCHIP_BPSK_HI,
        header_kbit:   KBIT_BPSK_HI,
        psdu_kbit:     KBIT_BPSK_HI,
        rate_reserved: 1'b0,
        scrambler_on:  1'b0
    };

endpackage

// [logic/phy_mode_if.sv]
interface phy_mode_if;
    import phy_mode_pkg::*;

    logic [7:0] cfg;
    phy_mode_t  mode;

    modport owner   (output cfg, input mode);
    modport decoder (input cfg, output mode);
endinterface

// [logic/phy_mode_decode.sv]
module phy_mode_decode
    import phy_mode_pkg::*;
(
    phy_mode_if.decoder dec
);

    logic       oqpsk;
    logic       chip_hi;
    logic [1:0] rate_sel;

    // only the low mode field takes part in the decode
    assign oqpsk    = dec.cfg[MOD_SEL_BIT];
    assign chip_hi  = dec.cfg[CHIP_RATE_BIT];
    assign rate_sel = dec.cfg[RATE_SEL_MSB:RATE_SEL_LSB];

    // ------------------------------------------------------------
    // mode table
    // ------------------------------------------------------------
    always_comb begin
        dec.mode               = PHY_MODE_RST;
        dec.mode.rate_reserved = 1'b0;
        if (!oqpsk) begin
            dec.mode.modulation = MOD_BPSK;
            dec.mode.tx_shaping = SHAPE_RC_1_0;
            dec.mode.chip_kchip = chip_hi ? KCHIP_BPSK_HI
                                          : KCHIP_BPSK_LO;
            dec.mode.header_kbit = chip_hi ? KBIT_BPSK_HI
                                           : KBIT_BPSK_LO;
            dec.mode.psdu_kbit  = dec.mode.header_kbit;
        end else begin
            dec.mode.modulation = MOD_OQPSK;
            dec.mode.chip_kchip = chip_hi ? KCHIP_OQPSK_HI
                                          : KCHIP_OQPSK_LO;
            dec.mode.header_kbit = chip_hi ? KBIT_OQ_HI_X1
                                           : KBIT_OQ_LO_X1;
            // shaping select only counts at the high chip rate
            if (!chip_hi) begin
                dec.mode.tx_shaping = SHAPE_SIN_RC_0_2;
            end else if (dec.cfg[RC_SHAPE_BIT]) begin
                dec.mode.tx_shaping = SHAPE_RC_0_8;
            end else begin
                dec.mode.tx_shaping = SHAPE_HALF_SINE;
            end
            // payload rate applies to the psdu only
            unique case (rate_sel)
                RATE_SEL_BASE: begin
                    dec.mode.psdu_kbit = chip_hi ? KBIT_OQ_HI_X1
                                                 : KBIT_OQ_LO_X1;
                end
                RATE_SEL_X2: begin
                    dec.mode.psdu_kbit = chip_hi ? KBIT_OQ_HI_X2
                                                 : KBIT_OQ_LO_X2;
                end
                RATE_SEL_X4: begin
                    dec.mode.psdu_kbit = chip_hi ? KBIT_OQ_HI_X4
                                                 : KBIT_OQ_LO_X4;
                end
                RATE_SEL_RSVD: begin
                    dec.mode.psdu_kbit     = KBIT_NONE;
                    dec.mode.rate_reserved = 1'b1;
                end
            endcase
        end
        // scrambling only for o-qpsk at the four-fold rate
        dec.mode.scrambler_on = dec.cfg[SCRAM_EN_BIT] && oqpsk
                                && (rate_sel == RATE_SEL_X4);
    end

endmodule

// [testbench/phy_mode_config_decoder_asserts.sv]
module phy_mode_config_decoder_asserts
    import phy_mode_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic        clk_en_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [7:0]  phy_mode_control_o,
    input wire modulation_t tx_modulation_o,
    input wire modulation_t rx_modulation_o,
    input wire shaping_t    tx_shaping_o,
    input wire logic [9:0]  chip_rate_kchip_o,
    input wire logic        rx_chip_rate_hi_o,
    input wire logic [9:0]  header_rate_kbit_o,
    input wire logic [9:0]  psdu_rate_kbit_o,
    input wire logic [1:0]  rx_payload_rate_sel_o,
    input wire logic        rate_reserved_o,
    input wire logic        tx_scrambler_on_o,
    input wire logic        rx_scrambler_on_o
);
    // short aliases of the stored register
    logic [7:0] c;
    logic       oq;
    logic       hi;
    logic [1:0] rs;
    assign c  = phy_mode_control_o;
    assign oq = phy_mode_control_o[MOD_SEL_BIT];
    assign hi = phy_mode_control_o[CHIP_RATE_BIT];
    assign rs = phy_mode_control_o[RATE_SEL_MSB:RATE_SEL_LSB];

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // ------------------------------------------------------------
    // decode and register port properties
    // ------------------------------------------------------------
    property p_scram;
        tx_scrambler_on_o == (c[SCRAM_EN_BIT] && oq && rs == RATE_SEL_X4);
    endproperty
    a_scram: assert property (p_scram)
        else $error("scrambler wrong");
    property p_rx;
        rx_scrambler_on_o == (c[SCRAM_EN_BIT] && oq && rs == RATE_SEL_X4)
        && rx_chip_rate_hi_o == hi
        && rx_modulation_o == (oq ? MOD_OQPSK : MOD_BPSK)
        && rx_payload_rate_sel_o == rs;
    endproperty
    a_rx: assert property (p_rx)
        else $error("rx settings wrong");
    property p_hi_shape;
        oq && hi |-> tx_shaping_o ==
            (c[RC_SHAPE_BIT] ? SHAPE_RC_0_8 : SHAPE_HALF_SINE);
    endproperty
    a_hi_shape: assert property (p_hi_shape)
        else $error("shaping wrong");
    property p_mod;
        tx_modulation_o == (oq ? MOD_OQPSK : MOD_BPSK);
    endproperty
    a_mod: assert property (p_mod)
        else $error("modulation wrong");
    property p_chip;
        chip_rate_kchip_o == (oq ? (hi ? KCHIP_OQPSK_HI : KCHIP_OQPSK_LO)
                                 : (hi ? KCHIP_BPSK_HI : KCHIP_BPSK_LO));
    endproperty
    a_chip: assert property (p_chip)
        else $error("chip rate wrong");
    property p_low;
        oq && !hi |-> tx_shaping_o == SHAPE_SIN_RC_0_2;
    endproperty
    a_low: assert property (p_low)
        else $error("low shaping wrong");
    property p_rsvd;
        oq && rs == RATE_SEL_RSVD |->
            rate_reserved_o && psdu_rate_kbit_o == KBIT_NONE;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved rate wrong");
    property p_header;
        header_rate_kbit_o == (oq ? (hi ? KBIT_OQ_HI_X1 : KBIT_OQ_LO_X1)
                                  : (hi ? KBIT_BPSK_HI : KBIT_BPSK_LO));
    endproperty
    a_header: assert property (p_header)
        else $error("header rate wrong");
    property p_write;
        clk_en_i && reg_wr_i && reg_addr_i == PHY_MODE_CONTROL_ADDR
            |=> c == $past(reg_wdata_i);
    endproperty
    a_write: assert property (p_write)
        else $error("write lost");
    property p_read;
        clk_en_i && reg_rd_i |=> reg_rdata_o ==
            ($past(reg_addr_i) == PHY_MODE_CONTROL_ADDR ? $past(c)
                                                         : READ_UNMAPPED_VAL);
    endproperty
    a_read: assert property (p_read)
        else $error("read data wrong");
    property p_hold;
        !clk_en_i |=> $stable(c) && $stable(reg_rdata_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state moved");
endmodule

bind phy_mode_config_decoder phy_mode_config_decoder_asserts chk_u (
    .ref_clk_i, .rst_b_i, .clk_en_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .phy_mode_control_o, .tx_modulation_o,
    .rx_modulation_o, .tx_shaping_o, .chip_rate_kchip_o, .rx_chip_rate_hi_o,
    .header_rate_kbit_o, .psdu_rate_kbit_o, .rx_payload_rate_sel_o,
    .rate_reserved_o,
    .tx_scrambler_on_o, .rx_scrambler_on_o
);

// [testbench/phy_mode_config_decoder_tb_top.sv]
module phy_mode_config_decoder_tb_top
    import phy_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i, rst_b_i, clk_en_i, reg_wr_i, reg_rd_i;
    logic        transceiver_off_state_i, rx_chip_rate_hi_o, rate_reserved_o;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, phy_mode_control_o;
    modulation_t tx_modulation_o, rx_modulation_o;
    shaping_t    tx_shaping_o;
    logic [9:0]  chip_rate_kchip_o, header_rate_kbit_o, psdu_rate_kbit_o;
    logic [1:0]  rx_payload_rate_sel_o;
    logic        tx_scrambler_on_o, rx_scrambler_on_o, cfg_write_active_o;
    int          bad_count, tests_run;

    phy_mode_config_decoder dut_u (
        .ref_clk_i, .rst_b_i, .clk_en_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
        .reg_rd_i, .transceiver_off_state_i, .reg_rdata_o, .tx_modulation_o,
        .phy_mode_control_o, .rx_modulation_o, .tx_shaping_o,
        .chip_rate_kchip_o, .rx_chip_rate_hi_o, .header_rate_kbit_o,
        .psdu_rate_kbit_o, .rx_payload_rate_sel_o, .rate_reserved_o,
        .tx_scrambler_on_o, .rx_scrambler_on_o, .cfg_write_active_o
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [9:0] s, e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one write, request held across one rising edge
    task automatic wr(input logic [7:0] a, d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge ref_clk_i);
        reg_rd_i = 1'b0;
        check("rdata", {2'b00, reg_rdata_o}, {2'b00, e});
    endtask
    // expected decode of a register value
    task automatic check_mode(input logic [7:0] v);
        logic [9:0] ch, hd, ps;
        shaping_t   sh;
        logic       sc, rv;
        ch = v[3] ? (v[2] ? 10'h3e8 : 10'h190) : (v[2] ? 10'h258 : 10'h12c);
        hd = v[3] ? (v[2] ? 10'h0fa : 10'h064) : (v[2] ? 10'h028 : 10'h014);
        ps = (v[1:0] == 2'h3) ? 10'h000 : hd << v[1:0];
        if (!v[3])
            ps = hd;
        sh = v[4] ? SHAPE_RC_0_8 : SHAPE_HALF_SINE;
        if (!v[2])
            sh = SHAPE_SIN_RC_0_2;
        if (!v[3])
            sh = SHAPE_RC_1_0;
        sc = v[5] & v[3] & (v[1:0] == 2'h2);
        rv = v[3] & (v[1:0] == 2'h3);
        check("stored", {2'b00, phy_mode_control_o}, {2'b00, v});
        check("chip", chip_rate_kchip_o, ch);
        check("header", header_rate_kbit_o, hd);
        check("psdu", psdu_rate_kbit_o, ps);
        check("shape", {8'h00, tx_shaping_o}, {8'h00, sh});
        check("tx mod", {9'h000, tx_modulation_o}, {9'h000, v[3]});
        check("rx mod", {9'h000, rx_modulation_o}, {9'h000, v[3]});
        check("tx scram", {9'h000, tx_scrambler_on_o}, {9'h000, sc});
        check("rx scram", {9'h000, rx_scrambler_on_o}, {9'h000, sc});
        check("rx chip", {9'h000, rx_chip_rate_hi_o}, {9'h000, v[2]});
        check("sel", {8'h00, rx_payload_rate_sel_o}, {8'h00, v[1:0]});
        check("rsvd", {9'h000, rate_reserved_o}, {9'h000, rv});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        check_mode(8'h24);
        check("flag", {9'h000, cfg_write_active_o}, 10'h000);
        rd(8'h0c, 8'h24);
    endtask
    task t_all_codes;
        for (int i = 0; i < 256; i++) begin
            wr(8'h0c, i[7:0]);
            check_mode(i[7:0]);
        end
    endtask
    task t_bus;
        wr(8'h0c, 8'h2e);
        wr(8'h0d, 8'h00);
        check("unmapped", {2'b00, phy_mode_control_o}, 10'h02e);
        rd(8'h0d, 8'h00);
        clk_en_i = 1'b0;
        wr(8'h0c, 8'h08);
        check("frozen", {2'b00, phy_mode_control_o}, 10'h02e);
        clk_en_i = 1'b1;
        @(negedge ref_clk_i);
        reg_addr_i = 8'h0c;
        reg_wdata_i = 8'h08;
        reg_wr_i = 1'b1;
        reg_rd_i = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        check("old rdata", {2'b00, reg_rdata_o}, 10'h02e);
        check_mode(8'h08);
    endtask
    task t_flag_reset;
        transceiver_off_state_i = 1'b0;
        wr(8'h0c, 8'h0c);
        check("flag", {9'h000, cfg_write_active_o}, 10'h001);
        transceiver_off_state_i = 1'b1;
        wr(8'h0c, 8'h3e);
        check("flag", {9'h000, cfg_write_active_o}, 10'h000);
        transceiver_off_state_i = 1'b0;
        wr(8'h0c, 8'h3e);
        rst_b_i = 1'b0;
        @(negedge ref_clk_i);
        check_mode(8'h24);
        check("flag", {9'h000, cfg_write_active_o}, 10'h000);
        rst_b_i = 1'b1;
        transceiver_off_state_i = 1'b1;
        rd(8'h0c, 8'h24);
        check("flag", {9'h000, cfg_write_active_o}, 10'h000);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        bad_count++;
        report_and_stop();
    end
    initial begin
        rst_b_i = 1'b0;
        clk_en_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        transceiver_off_state_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        t_reset();
        t_all_codes();
        t_bus();
        t_flag_reset();
        report_and_stop();
    end
endmodule
